// *** rtl/eag_core.v ***
// Effective address generator with a classic Wishbone register slave.
//
// Behaviour
// - Operand selector splits into two 3-bit subfields.
// - Register field names register or special submode.
// - Extension words fetched before forming address.
// - Immediate and PC-relative reads are program space.
// - All operand writes go to data space.
// - Implicit stack pointer use needs no encoding.
// - Register direct takes operand, no memory access.
// - Indirect uses address register contents.
// - Postincrement adds one, two or four.
// - Byte on stack pointer steps by two.
// - Predecrement subtracts by size before use.
// - Displacement mode adds sign-extended 16-bit displacement.
// - Displacements sign extended to 32 bits.
// - Brief index sums register, 8-bit displacement, index.
// - Brief format adds index; full format adds it unless bit 6 is set.
// - Address register indexed mode data space except jumps.
// - Extension bit 15 picks data or address index.
// - Index register number from bits 14:12.
// - Bit 11 picks sign-extended word or long.
// - Bits 10:9 scale index by 1,2,4,8.
// - Base displacement form adds optional 16/32-bit displacement.
// - Mode 111 makes register field a submode.
// - PC-relative uses extension word address as PC.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "eag_defines.vh"

module eag_core
#(
	parameter ADDR_W = 8
)
(
	input  wire              clock,
	input  wire              nrst,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [ADDR_W-1:0] wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	output reg  [31:0]       ea_addr,
	output reg               ea_program_space,
	output reg               ea_valid,
	output wire              busy
);

	// ------------------------------------------------------------
	// State codes
	// ------------------------------------------------------------
	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_FETCH = 2'b01;
	localparam [1:0] ST_CALC  = 2'b10;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	reg [31:0] rf_reg [0:15];
	reg [4:0]  ctrl_reg;
	reg [15:0] opword_reg;
	reg [15:0] ext_in_reg [0:2];
	reg [15:0] ext_w_reg [0:2];
	reg [31:0] pc_reg;
	reg [31:0] operand_reg;
	reg        done_reg;
	reg        regdir_reg;
	reg        illegal_reg;
	reg [1:0]  words_reg;
	reg [1:0]  state_reg;
	reg [1:0]  fetch_cnt_reg;
	integer    i;

	// ------------------------------------------------------------
	// Operand selector decode
	// ------------------------------------------------------------
	wire [2:0] mode_sel = opword_reg[5:3];
	wire [2:0] reg_sel  = opword_reg[2:0];
	wire [1:0] op_size  = ctrl_reg[`EAG_CTRL_SIZE_HI:`EAG_CTRL_SIZE_LO];
	wire       op_write = ctrl_reg[`EAG_CTRL_WRITE];
	wire       op_jump  = ctrl_reg[`EAG_CTRL_JUMP];
	wire       pc_sub   = (mode_sel == `EAG_MODE_SPECIAL) &&
	                      ((reg_sel == `EAG_SUB_PCDISP) || (reg_sel == `EAG_SUB_PCINDEX));
	wire       idx_mode = (mode_sel == `EAG_MODE_INDEX) ||
	                      ((mode_sel == `EAG_MODE_SPECIAL) && (reg_sel == `EAG_SUB_PCINDEX));
	wire       imm_sub  = (mode_sel == `EAG_MODE_SPECIAL) && (reg_sel == `EAG_SUB_IMM);

	// ------------------------------------------------------------
	// Number of extension words the mode needs, judged from the
	// opword and the first staged extension word.
	// ------------------------------------------------------------
	reg [1:0] need_words;
	always @*
	begin
		need_words = 2'd0;
		if (mode_sel == `EAG_MODE_DISP || (mode_sel == `EAG_MODE_SPECIAL && reg_sel == `EAG_SUB_PCDISP))
			need_words = 2'd1;
		else if (idx_mode)
		begin
			if (!ext_in_reg[0][`EAG_EXT_FULL])
				need_words = 2'd1;
			else if (ext_in_reg[0][5:4] == `EAG_BD_WORD)
				need_words = 2'd2;
			else if (ext_in_reg[0][5:4] == `EAG_BD_LONG)
				need_words = 2'd3;
			else
				need_words = 2'd1;
		end
		else if (imm_sub)
			need_words = (op_size == `EAG_SIZE_LONG) ? 2'd2 : 2'd1;
	end

	// ------------------------------------------------------------
	// Index operand from the first extension word.
	// ------------------------------------------------------------
	wire [15:0] ext0      = ext_w_reg[0];
	wire [3:0]  idx_num   = {ext0[`EAG_EXT_DA], ext0[14:12]};
	wire [31:0] idx_raw   = rf_reg[idx_num];
	wire [31:0] idx_val   = ext0[`EAG_EXT_WL] ? idx_raw :
	                        {{16{idx_raw[15]}}, idx_raw[15:0]};
	wire [31:0] idx_scale = idx_val << ext0[10:9];
	wire        is_full   = ext0[`EAG_EXT_FULL];
	wire        idx_keep  = !(is_full && ext0[`EAG_EXT_IS]);
	wire [31:0] idx_term  = idx_keep ? idx_scale : 32'h0000_0000;

	// Brief and word displacements are widened to 32 bits first.
	wire [31:0] d8_ext  = {{24{ext0[7]}}, ext0[7:0]};
	wire [31:0] d16_ext = {{16{ext0[15]}}, ext0};
	wire [31:0] bdw_ext = {{16{ext_w_reg[1][15]}}, ext_w_reg[1]};
	reg  [31:0] bd_term;
	always @*
	begin
		case (ext0[5:4])
			`EAG_BD_WORD: bd_term = bdw_ext;
			`EAG_BD_LONG: bd_term = {ext_w_reg[1], ext_w_reg[2]};
			default:      bd_term = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Address formation and register update for the chosen mode.
	// ------------------------------------------------------------
	wire [31:0] an_val  = rf_reg[{1'b1, reg_sel}];
	wire        on_sp   = (reg_sel == `EAG_SP_NUM);
	reg  [31:0] step;
	reg  [31:0] base;
	reg  [31:0] ea_next;
	reg         upd_an;
	reg  [31:0] an_next;
	reg         prog_next;
	reg         regdir_next;
	reg         bad_next;
	always @*
	begin
		case (op_size)
			`EAG_SIZE_BYTE: step = on_sp ? 32'h0000_0002 : 32'h0000_0001;
			`EAG_SIZE_WORD: step = 32'h0000_0002;
			default:        step = 32'h0000_0004;
		endcase
		base        = pc_sub ? pc_reg : an_val;
		if (idx_mode && is_full && ext0[`EAG_EXT_BS])
			base = 32'h0000_0000;
		ea_next     = base;
		upd_an      = 1'b0;
		an_next     = an_val;
		prog_next   = 1'b0;
		regdir_next = 1'b0;
		bad_next    = 1'b0;
		case (mode_sel)
			`EAG_MODE_DREG, `EAG_MODE_AREG:
			begin
				regdir_next = 1'b1;
				ea_next     = 32'h0000_0000;
			end
			`EAG_MODE_IND:
				ea_next = an_val;
			`EAG_MODE_POSTINC:
			begin
				ea_next = an_val;
				upd_an  = 1'b1;
				an_next = an_val + step;
			end
			`EAG_MODE_PREDEC:
			begin
				upd_an  = 1'b1;
				an_next = an_val - step;
				ea_next = an_val - step;
			end
			`EAG_MODE_DISP:
				ea_next = an_val + d16_ext;
			`EAG_MODE_INDEX:
			begin
				if (is_full)
					ea_next = base + idx_term + bd_term;
				else
					ea_next = base + d8_ext + idx_term;
				prog_next = op_jump;
			end
			default:
			begin
				case (reg_sel)
					`EAG_SUB_PCDISP:
						ea_next = pc_reg + d16_ext;
					`EAG_SUB_PCINDEX:
					begin
						if (is_full)
							ea_next = base + idx_term + bd_term;
						else
							ea_next = base + d8_ext + idx_term;
					end
					`EAG_SUB_IMM:
						ea_next = pc_reg;
					default:
						bad_next = 1'b1;
				endcase
				prog_next = pc_sub || imm_sub;
				if (op_write && (pc_sub || imm_sub))
					bad_next = 1'b1;
			end
		endcase
		if (idx_mode && is_full && (ext0[5:4] == `EAG_BD_RESERVED || ext0[2:0] != 3'h0))
			bad_next = 1'b1;
		if (op_write)
			prog_next = 1'b0;
	end

	// ------------------------------------------------------------
	// Wishbone decode and byte lane merge.
	// ------------------------------------------------------------
	wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land at the edge that carries the acknowledge.
	wire        wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	wire        rf_hit   = (wb_adr_i[ADDR_W-1:6] == 2'b01);
	wire [3:0]  rf_idx   = wb_adr_i[5:2];
	wire [31:0] status_w = {24'h00_0000, words_reg, 1'b0, illegal_reg, regdir_reg,
	                        ea_program_space, done_reg, busy};

	function [31:0] lane_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel;
		integer      b;
		begin
			lane_merge = old_v;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
		end
	endfunction

	// Byte lane merges of each writable register except control with the bus data.
	wire [31:0] op_mrg = lane_merge({16'h0000, opword_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] e0_mrg = lane_merge({16'h0000, ext_in_reg[0]}, wb_dat_i, wb_sel_i);
	wire [31:0] e1_mrg = lane_merge({16'h0000, ext_in_reg[1]}, wb_dat_i, wb_sel_i);
	wire [31:0] e2_mrg = lane_merge({16'h0000, ext_in_reg[2]}, wb_dat_i, wb_sel_i);
	wire [31:0] pc_mrg = lane_merge(pc_reg, wb_dat_i, wb_sel_i);
	wire [31:0] rf_mrg = lane_merge(rf_reg[rf_idx], wb_dat_i, wb_sel_i);

	// Operand seen by software: a register for direct modes, the stream for immediates.
	reg  [31:0] operand_next;
	always @*
	begin
		operand_next = 32'h0000_0000;
		if (regdir_next)
			operand_next = rf_reg[{mode_sel[0], reg_sel}];
		else if (imm_sub)
		begin
			case (op_size)
				`EAG_SIZE_BYTE: operand_next = {24'h00_0000, ext_w_reg[0][7:0]};
				`EAG_SIZE_WORD: operand_next = {16'h0000, ext_w_reg[0]};
				default:        operand_next = {ext_w_reg[0], ext_w_reg[1]};
			endcase
		end
	end

	assign busy = (state_reg != ST_IDLE);

	// ------------------------------------------------------------
	// Bus answer: ack one cycle after the request, dropped after one.
	// ------------------------------------------------------------
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
			begin
				if (rf_hit)
					wb_dat_o <= rf_reg[rf_idx];
				else
				begin
					case (wb_adr_i)
						`EAG_OFF_CTRL:    wb_dat_o <= {27'h000_0000, ctrl_reg[4:1], 1'b0};
						`EAG_OFF_OPWORD:  wb_dat_o <= {16'h0000, opword_reg};
						`EAG_OFF_EXT0:    wb_dat_o <= {16'h0000, ext_in_reg[0]};
						`EAG_OFF_EXT1:    wb_dat_o <= {16'h0000, ext_in_reg[1]};
						`EAG_OFF_EXT2:    wb_dat_o <= {16'h0000, ext_in_reg[2]};
						`EAG_OFF_PC:      wb_dat_o <= pc_reg;
						`EAG_OFF_STATUS:  wb_dat_o <= status_w;
						`EAG_OFF_EA:      wb_dat_o <= ea_addr;
						`EAG_OFF_OPERAND: wb_dat_o <= operand_reg;
						default:          wb_dat_o <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers; configuration writes are ignored while busy.
	// ------------------------------------------------------------
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_reg      <= `EAG_CTRL_RESET;
			opword_reg    <= 16'h0000;
			ext_in_reg[0] <= 16'h0000;
			ext_in_reg[1] <= 16'h0000;
			ext_in_reg[2] <= 16'h0000;
			pc_reg        <= 32'h0000_0000;
			for (i = 0; i < 16; i = i + 1)
				rf_reg[i] <= 32'h0000_0000;
		end
		else
		begin
			ctrl_reg[`EAG_CTRL_GO] <= 1'b0;
			if (wb_wr && !busy)
			begin
				if (rf_hit)
					rf_reg[rf_idx] <= rf_mrg;
				else
				begin
					case (wb_adr_i)
						`EAG_OFF_CTRL:   if (wb_sel_i[0]) ctrl_reg <= wb_dat_i[4:0];
						`EAG_OFF_OPWORD: opword_reg    <= op_mrg[15:0];
						`EAG_OFF_EXT0:   ext_in_reg[0] <= e0_mrg[15:0];
						`EAG_OFF_EXT1:   ext_in_reg[1] <= e1_mrg[15:0];
						`EAG_OFF_EXT2:   ext_in_reg[2] <= e2_mrg[15:0];
						`EAG_OFF_PC:     pc_reg        <= pc_mrg;
						default:         ;
					endcase
				end
			end
			// The engine only updates while busy, so it never meets a software write.
			if (state_reg == ST_CALC && upd_an)
				rf_reg[{1'b1, reg_sel}] <= an_next;
		end
	end

	// ------------------------------------------------------------
	// Sequencer: start, copy extension words one a cycle, form address.
	// ------------------------------------------------------------
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg        <= ST_IDLE;
			fetch_cnt_reg    <= 2'd0;
			ext_w_reg[0]     <= 16'h0000;
			ext_w_reg[1]     <= 16'h0000;
			ext_w_reg[2]     <= 16'h0000;
			ea_addr          <= 32'h0000_0000;
			ea_program_space <= 1'b0;
			ea_valid         <= 1'b0;
			done_reg         <= 1'b0;
			regdir_reg       <= 1'b0;
			illegal_reg      <= 1'b0;
			words_reg        <= 2'd0;
			operand_reg      <= 32'h0000_0000;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (ctrl_reg[`EAG_CTRL_GO])
					begin
						state_reg     <= ST_FETCH;
						fetch_cnt_reg <= 2'd0;
						ea_valid      <= 1'b0;
						done_reg      <= 1'b0;
					end
				ST_FETCH:
					if (fetch_cnt_reg == need_words)
						state_reg <= ST_CALC;
					else
					begin
						ext_w_reg[fetch_cnt_reg] <= ext_in_reg[fetch_cnt_reg];
						fetch_cnt_reg            <= fetch_cnt_reg + 2'd1;
					end
				ST_CALC:
				begin
					ea_addr          <= ea_next;
					ea_program_space <= prog_next;
					regdir_reg       <= regdir_next;
					illegal_reg      <= bad_next;
					words_reg        <= need_words;
					operand_reg      <= operand_next;
					ea_valid         <= 1'b1;
					done_reg         <= 1'b1;
					state_reg        <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule // eag_core

// *** common/eag_defines.vh ***
// Register offsets, field positions and codes of the effective address generator.
`ifndef EAG_DEFINES_VH
`define EAG_DEFINES_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define EAG_OFF_CTRL      8'h00
`define EAG_OFF_OPWORD    8'h04
`define EAG_OFF_EXT0      8'h08
`define EAG_OFF_EXT1      8'h0C
`define EAG_OFF_EXT2      8'h10
`define EAG_OFF_PC        8'h14
`define EAG_OFF_STATUS    8'h18
`define EAG_OFF_EA        8'h1C
`define EAG_OFF_OPERAND   8'h20
`define EAG_OFF_RF_BASE   8'h40
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define EAG_CTRL_GO       0
`define EAG_CTRL_SIZE_LO  1
`define EAG_CTRL_SIZE_HI  2
`define EAG_CTRL_WRITE    3
`define EAG_CTRL_JUMP     4
`define EAG_CTRL_RESET    5'h0_0
// ------------------------------------------------------------
// Operand sizes and addressing modes
// ------------------------------------------------------------
`define EAG_SIZE_BYTE     2'h0
`define EAG_SIZE_WORD     2'h1
`define EAG_SIZE_LONG     2'h2
`define EAG_MODE_DREG     3'h0
`define EAG_MODE_AREG     3'h1
`define EAG_MODE_IND      3'h2
`define EAG_MODE_POSTINC  3'h3
`define EAG_MODE_PREDEC   3'h4
`define EAG_MODE_DISP     3'h5
`define EAG_MODE_INDEX    3'h6
`define EAG_MODE_SPECIAL  3'h7
`define EAG_SUB_PCDISP    3'h2
`define EAG_SUB_PCINDEX   3'h3
`define EAG_SUB_IMM       3'h4
`define EAG_SP_NUM        3'h7
// ------------------------------------------------------------
// Extension word fields and base displacement size codes
// ------------------------------------------------------------
`define EAG_EXT_DA        15
`define EAG_EXT_WL        11
`define EAG_EXT_FULL      8
`define EAG_EXT_BS        7
`define EAG_EXT_IS        6
`define EAG_BD_RESERVED   2'h0
`define EAG_BD_NULL       2'h1
`define EAG_BD_WORD       2'h2
`define EAG_BD_LONG       2'h3
`endif

// *** tb/eag_checker.sv ***
// Port checks for the effective address generator.
`timescale 1ns/1ps
`include "eag_defines.vh"

module eag_checker
#(
	parameter ADDR_W = 8
)
(
	input wire              clock,
	input wire              nrst,
	input wire              wb_cyc_i,
	input wire              wb_stb_i,
	input wire              wb_we_i,
	input wire [ADDR_W-1:0] wb_adr_i,
	input wire [3:0]        wb_sel_i,
	input wire [31:0]       wb_dat_i,
	input wire [31:0]       wb_dat_o,
	input wire              wb_ack_o,
	input wire [31:0]       ea_addr,
	input wire              ea_program_space,
	input wire              ea_valid,
	input wire              busy
);
	reg  [4:0]  ctrl_reg;
	reg  [15:0] op_reg;
	wire        wr_hit;
	wire        go_hit;
	wire [2:0]  mode;
	wire [2:0]  rsel;

	// Decode of acknowledged writes and of the shadowed selector fields.
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign go_hit = wr_hit && (wb_adr_i == `EAG_OFF_CTRL) && wb_dat_i[`EAG_CTRL_GO];
	assign mode   = op_reg[5:3];
	assign rsel   = op_reg[2:0];

	// Shadow the control and operation word as software writes them.
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_reg <= 5'h0_0;
			op_reg   <= 16'h0000;
		end
		else if (wr_hit && wb_adr_i == `EAG_OFF_CTRL)
			ctrl_reg <= wb_dat_i[4:0];
		else if (wr_hit && wb_adr_i == `EAG_OFF_OPWORD)
			op_reg <= wb_dat_i[15:0];
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	AST_ACK_REQ:
		assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without request");
	AST_ACK_DROP:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	AST_GO_DONE:
		assert property (go_hit && mode >= 3'h2 |-> ##[4:64] ea_valid) else $error("no address after start");
	AST_WRITE_DATA:
		assert property ($rose(ea_valid) && ctrl_reg[3] |-> !ea_program_space) else $error("write in program space");
	AST_PC_PROG:
		assert property ($rose(ea_valid) && !ctrl_reg[3] && mode == 3'h7 && (rsel == 3'h2 || rsel == 3'h3)
			|-> ea_program_space) else $error("pc relative read not program");
	AST_IMM_PROG:
		assert property ($rose(ea_valid) && !ctrl_reg[3] && mode == 3'h7 && rsel == 3'h4 |-> ea_program_space)
			else $error("immediate not program");
	AST_MEM_DATA:
		assert property ($rose(ea_valid) && mode >= 3'h2 && mode <= 3'h5 |-> !ea_program_space)
			else $error("register memory mode not data");
	AST_INDEX_DATA:
		assert property ($rose(ea_valid) && mode == 3'h6 && !ctrl_reg[4] |-> !ea_program_space)
			else $error("indexed mode not data");
endmodule // eag_checker

bind eag_core eag_checker #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ea_addr(ea_addr), .ea_program_space(ea_program_space),
	.ea_valid(ea_valid), .busy(busy));

// *** tb/tb.sv ***
// Register level bench for the effective address generator.
`timescale 1ns/1ps
`include "eag_defines.vh"

module tb;
	reg         clock;
	reg         nrst;
	reg         wb_cyc_i;
	reg         wb_stb_i;
	reg         wb_we_i;
	reg  [7:0]  wb_adr_i;
	reg  [3:0]  wb_sel_i;
	reg  [31:0] wb_dat_i;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o;
	wire [31:0] ea_addr;
	wire        ea_program_space;
	wire        ea_valid;
	wire        busy;
	integer     mismatches;
	integer     tests_run;
	integer     i;
	reg  [31:0] rd;

	eag_core #(.ADDR_W(8)) DUT (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ea_addr(ea_addr), .ea_program_space(ea_program_space), .ea_valid(ea_valid),
		.busy(busy));

	// Free running system clock.
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task tally_and_finish;
		begin
			if (mismatches == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	task chk(input [31:0] g, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e)
			begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	// One classic bus cycle; entered just after a rising edge, holds until ack.
	task wb_access(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i  <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			n = 0;
			@(posedge clock);
			while (wb_ack_o !== 1'b1 && n < 100)
			begin
				@(posedge clock);
				n = n + 1;
			end
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			if (n == 100)
			begin
				mismatches = mismatches + 1;
				tally_and_finish;
			end
			@(posedge clock);
		end
	endtask

	// Load selector and extension, start, and wait for the formed address.
	task run(input [15:0] op, input [15:0] ext, input [4:0] c);
		integer n;
		begin
			wb_access(1'b1, `EAG_OFF_OPWORD, {16'h0000, op});
			wb_access(1'b1, `EAG_OFF_EXT0, {16'h0000, ext});
			wb_access(1'b1, `EAG_OFF_CTRL, {27'h000_0000, c});
			n = 0;
			@(negedge clock);
			while (!(ea_valid === 1'b1 && busy === 1'b0) && n < 100)
			begin
				@(negedge clock);
				n = n + 1;
			end
			if (n == 100)
			begin
				mismatches = mismatches + 1;
				tally_and_finish;
			end
			@(posedge clock);
		end
	endtask

	// Main sequence: address register 2 at 0x68, data register 3 at 0x4C, stack pointer at 0x7C.
	initial
	begin
		mismatches = 0;
		tests_run = 0;
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		wb_access(1'b0, `EAG_OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb_access(1'b0, 8'h3C, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb_access(1'b1, 8'h68, 32'h0000_1000);
		wb_access(1'b1, 8'h4C, 32'h1234_FFFE);
		wb_access(1'b1, 8'h7C, 32'h0000_2000);
		run(16'h0012, 16'h0000, 5'h05);
		chk(ea_addr, 32'h0000_1000);
		chk({31'h0, ea_program_space}, 32'h0000_0000);
		run(16'h001A, 16'h0000, 5'h05);
		chk(ea_addr, 32'h0000_1000);
		wb_access(1'b0, 8'h68, 32'h0000_0000);
		chk(rd, 32'h0000_1004);
		run(16'h001F, 16'h0000, 5'h01);
		chk(ea_addr, 32'h0000_2000);
		wb_access(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd, 32'h0000_2002);
		run(16'h0027, 16'h0000, 5'h01);
		chk(ea_addr, 32'h0000_2000);
		run(16'h0022, 16'h0000, 5'h03);
		chk(ea_addr, 32'h0000_1002);
		run(16'h002A, 16'hFFF0, 5'h05);
		chk(ea_addr, 32'h0000_0FF2);
		for (i = 0; i < 4; i = i + 1)
		begin
			run(16'h0032, {4'h3, 1'b0, i[1:0], 1'b0, 8'h80}, 5'h05);
			chk(ea_addr, 32'h0000_1002 - 32'h0000_0080 - (32'h0000_0002 << i));
		end
		run(16'h0032, 16'hAA04, 5'h05);
		chk(ea_addr, 32'h0000_300A);
		chk({31'h0, ea_program_space}, 32'h0000_0000);
		wb_access(1'b1, `EAG_OFF_EXT1, 32'h0000_0100);
		run(16'h0032, 16'h3120, 5'h05);
		chk(ea_addr, 32'h0000_1100);
		run(16'h0012, 16'h0000, 5'h0D);
		chk({31'h0, ea_program_space}, 32'h0000_0000);
		run(16'h003A, 16'h0010, 5'h05);
		chk({31'h0, ea_program_space}, 32'h0000_0001);
		run(16'h003C, 16'h0055, 5'h03);
		chk({31'h0, ea_program_space}, 32'h0000_0001);
		wb_access(1'b0, `EAG_OFF_OPERAND, 32'h0000_0000);
		chk(rd, 32'h0000_0055);
		run(16'h0003, 16'h0000, 5'h05);
		wb_access(1'b0, `EAG_OFF_OPERAND, 32'h0000_0000);
		chk(rd, 32'h1234_FFFE);
		tally_and_finish;
	end
endmodule // tb
